// >>> charge_port_cfg.svh
// timing counts and encodings for the charge-port mode controller
`ifndef CHARGE_PORT_CFG_SVH
`define CHARGE_PORT_CFG_SVH

`define CP_CLK_PERIOD_NS        5
`define CP_DEBOUNCE_US          100
`define CP_DEBOUNCE_CYC         ((`CP_DEBOUNCE_US * 1000) / `CP_CLK_PERIOD_NS)
`define CP_DWELL_12V_US         500
`define CP_DWELL_12V_CYC        ((`CP_DWELL_12V_US * 1000) / `CP_CLK_PERIOD_NS)
`define CP_MODE_SEL_SDP         2'h2
`define CP_MODE_SEL_CDP         2'h3
`define CP_MODE_SEL_DCP         2'h1
`define CP_MODE_SEL_RSVD        2'h0

`endif

// >>> charge_port_pkg.sv
// types shared by the charge-port mode controller
package charge_port_pkg;

    typedef enum logic [2:0] {
        ST_SHUTDOWN = 3'h0,
        ST_STANDBY  = 3'h1,
        ST_DEBOUNCE = 3'h3,
        ST_ATTACHED = 3'h2,
        ST_DETACH   = 3'h6
    } port_state_t;

    typedef enum logic [1:0] {
        DCP_DIV3  = 2'h0,
        DCP_V12   = 2'h1,
        DCP_SHORT = 2'h3
    } dcp_state_t;

    typedef enum logic [1:0] {
        USB_NONE = 2'h0,
        USB_SDP  = 2'h1,
        USB_CDP  = 2'h2,
        USB_DCP  = 2'h3
    } usb_mode_t;

endpackage : charge_port_pkg

// >>> dcp_auto_detect.sv
// dedicated-charging auto-detect state machine
`timescale 1ns/1ps
`default_nettype none
`include "charge_port_cfg.svh"

module dcp_auto_detect #(
    parameter int unsigned DWELL_CYC = `CP_DWELL_12V_CYC
) (
    input  wire logic                     i_clk_sys,
    input  wire logic                     i_sys_rst,
    input  wire logic                     i_clk_en,
    input  wire logic                     i_active,
    input  wire logic                     i_short_dev_seen,
    input  wire logic                     i_line_released,
    output charge_port_pkg::dcp_state_t   o_state
);

    localparam int unsigned CW = $clog2(DWELL_CYC + 1);

    charge_port_pkg::dcp_state_t state_q;
    logic [CW-1:0]               dwell_q;

    // ------------------------------------------------------------
    // scheme sequencing
    // ------------------------------------------------------------
    // dwell restarts on every entry to the 1.2 V scheme
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state_q <= charge_port_pkg::DCP_DIV3;
            dwell_q <= '0;
        end else if (i_clk_en) begin
            if (!i_active) begin
                state_q <= charge_port_pkg::DCP_DIV3;
                dwell_q <= '0;
            end else begin
                case (state_q)
                    charge_port_pkg::DCP_DIV3: begin
                        // a divider-3 device never loads the lines, so it stays here
                        if (i_short_dev_seen) begin
                            state_q <= charge_port_pkg::DCP_V12;
                            dwell_q <= '0;
                        end
                    end
                    charge_port_pkg::DCP_V12: begin
                        if (i_line_released) begin
                            state_q <= charge_port_pkg::DCP_DIV3;
                        end else if (dwell_q >= CW'(DWELL_CYC - 1)) begin
                            state_q <= charge_port_pkg::DCP_SHORT;
                        end else begin
                            dwell_q <= dwell_q + 1'b1;
                        end
                    end
                    charge_port_pkg::DCP_SHORT: begin
                        if (i_line_released) begin
                            state_q <= charge_port_pkg::DCP_DIV3;
                        end
                    end
                    default: begin
                        state_q <= charge_port_pkg::DCP_DIV3;
                    end
                endcase
            end
        end
    end

    assign o_state = state_q;

endmodule // dcp_auto_detect
`default_nettype wire

// >>> charge_port_ctrl.sv
// port-mode control for a usb type-c downstream charging port
//
// Summary of operation
// - after supply clears lockout, start only while the power-on gate is high
// - after start-up, watch both configuration-channel pins for a sink
// - turn buck on only after sink detection holds for the debounce time
// - drive load-switch gate while a sink is attached
// - source vconn onto the unused configuration pin when it shows ra
// - enter type-c first, then sdp, cdp or dcp from mode select and data lines
// - sdp supplies 500 ma usb2 or 900 ma usb3; host must be active
// - dedicated charging has one dcp-auto state choosing among three schemes
// - shorted mode joins d+ and d- through at most 200 ohms
// - divider-3 scheme presents 2.7 v on both data lines
// - 1.2 v scheme shorts and pulls lines to 1.2 v, then goes shorted
// - auto-detect machine starts in divider-3
// - shorted-standard device passes briefly through 1.2 v before shorted mode
// - hold 1.2 v or shorted until the line is released, then divider-3
// - a divider-3 device keeps the machine in divider-3
// - pass switches closed in cdp or sdp only while enabled and attached
// - in cdp the pass switches stay closed during the handshake
// - external-fet current limit opens the pass switches
// - vconn current limit leaves the pass switches alone
// - mode select: 10 sdp 1.5 a, 11 cdp 3 a, 01 dcp auto 3 a, 00 reserved
// - enabled with no valid rd: low-power standby with buck off
`timescale 1ns/1ps
`default_nettype none
`include "charge_port_cfg.svh"

module charge_port_ctrl #(
    parameter int unsigned DEBOUNCE_CYC = `CP_DEBOUNCE_CYC,
    parameter int unsigned DWELL_CYC    = `CP_DWELL_12V_CYC,
    parameter bit          HAS_DCP      = 1'b1
) (
    input  wire logic  i_clk_sys,
    input  wire logic  i_sys_rst,
    input  wire logic  i_clk_en,
    input  wire logic  i_power_on_gate_input,
    input  wire logic  i_supply_ok,
    input  wire logic  i_cc1_rd,
    input  wire logic  i_cc2_rd,
    input  wire logic  i_cc1_ra,
    input  wire logic  i_cc2_ra,
    input  wire logic  i_mode_select_a,
    input  wire logic  i_mode_select_b,
    input  wire logic  i_host_active,
    input  wire logic  i_usb3_host,
    input  wire logic  i_dcp_short_dev_seen,
    input  wire logic  i_dcp_line_released,
    input  wire logic  i_ext_fet_ilim,
    input  wire logic  i_vconn_ilim,
    output logic       o_buck_enable,
    output logic       o_load_switch_gate_drive,
    output logic       o_vconn_cc1,
    output logic       o_vconn_cc2,
    output logic       o_cc_polarity,
    output logic       o_pass_switch_on,
    output logic       o_dcp_short_en,
    output logic       o_dcp_div3_en,
    output logic       o_dcp_v12_en,
    output logic       o_cdp_handshake_en,
    output logic [1:0] o_usb_mode,
    output logic       o_adv_3a,
    output logic       o_sdp_900ma,
    output logic       o_charge_allowed,
    output logic       o_mode_reserved
);

    localparam int unsigned DBW = $clog2(DEBOUNCE_CYC + 1);

    // ------------------------------------------------------------
    // mode-select decode
    // ------------------------------------------------------------
    // used by both the mode register and the reserved flag
    function automatic charge_port_pkg::usb_mode_t decode_mode(input logic a, input logic b, input logic dcp_ok);
        logic [1:0] sel;
        sel = {a, b};
        case (sel)
            `CP_MODE_SEL_SDP: decode_mode = charge_port_pkg::USB_SDP;
            `CP_MODE_SEL_CDP: decode_mode = charge_port_pkg::USB_CDP;
            `CP_MODE_SEL_DCP: decode_mode = dcp_ok ? charge_port_pkg::USB_DCP : charge_port_pkg::USB_NONE;
            default:          decode_mode = charge_port_pkg::USB_NONE;
        endcase
    endfunction

    charge_port_pkg::port_state_t state_q;
    logic [DBW-1:0]               deb_q;
    logic                         cc_sel_q;
    logic                         enabled;
    logic                         sink_seen;
    logic                         sink_on_sel;
    charge_port_pkg::usb_mode_t   mode_now;
    charge_port_pkg::dcp_state_t  dcp_state;
    logic                         attached;

    assign enabled     = i_power_on_gate_input & i_supply_ok;
    assign sink_seen   = i_cc1_rd | i_cc2_rd;
    assign sink_on_sel = cc_sel_q ? i_cc2_rd : i_cc1_rd;
    assign mode_now    = decode_mode(i_mode_select_a, i_mode_select_b, HAS_DCP);
    assign attached    = (state_q == charge_port_pkg::ST_ATTACHED);

    // ------------------------------------------------------------
    // attach state machine
    // ------------------------------------------------------------
    // losing enable or supply drops straight to shutdown from any state
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state_q  <= charge_port_pkg::ST_SHUTDOWN;
            deb_q    <= '0;
            cc_sel_q <= 1'b0;
        end else if (i_clk_en) begin
            if (!enabled) begin
                state_q <= charge_port_pkg::ST_SHUTDOWN;
                deb_q   <= '0;
            end else begin
                case (state_q)
                    charge_port_pkg::ST_SHUTDOWN: begin
                        state_q <= charge_port_pkg::ST_STANDBY;
                    end
                    charge_port_pkg::ST_STANDBY: begin
                        deb_q <= '0;
                        if (sink_seen) begin
                            cc_sel_q <= ~i_cc1_rd;              // prefer cc1 if both show rd
                            state_q  <= charge_port_pkg::ST_DEBOUNCE;
                        end
                    end
                    charge_port_pkg::ST_DEBOUNCE: begin
                        if (!sink_on_sel) begin
                            state_q <= charge_port_pkg::ST_STANDBY;
                        end else if (deb_q >= DBW'(DEBOUNCE_CYC - 1)) begin
                            state_q <= charge_port_pkg::ST_ATTACHED;
                        end else begin
                            deb_q <= deb_q + 1'b1;
                        end
                    end
                    charge_port_pkg::ST_ATTACHED: begin
                        if (!sink_on_sel) begin
                            state_q <= charge_port_pkg::ST_DETACH;
                        end
                    end
                    charge_port_pkg::ST_DETACH: begin
                        // one cycle to drop power before watching again
                        state_q <= charge_port_pkg::ST_STANDBY;
                    end
                    default: begin
                        state_q <= charge_port_pkg::ST_SHUTDOWN;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // dedicated-charging scheme selection
    // ------------------------------------------------------------
    dcp_auto_detect #(
        .DWELL_CYC (DWELL_CYC)
    ) u_dcp (
        .i_clk_sys        (i_clk_sys),
        .i_sys_rst        (i_sys_rst),
        .i_clk_en         (i_clk_en),
        .i_active         (attached && mode_now == charge_port_pkg::USB_DCP),
        .i_short_dev_seen (i_dcp_short_dev_seen),
        .i_line_released  (i_dcp_line_released),
        .o_state          (dcp_state)
    );

    // ------------------------------------------------------------
    // power path outputs
    // ------------------------------------------------------------
    // buck and gate follow attach and rd on the selected pin; standby keeps vbus at zero
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_buck_enable            <= 1'b0;
            o_load_switch_gate_drive <= 1'b0;
            o_vconn_cc1              <= 1'b0;
            o_vconn_cc2              <= 1'b0;
            o_cc_polarity            <= 1'b0;
        end else if (i_clk_en) begin
            o_buck_enable            <= attached & sink_on_sel;
            o_load_switch_gate_drive <= attached & sink_on_sel;
            o_vconn_cc1              <= attached & cc_sel_q & i_cc1_ra;
            o_vconn_cc2              <= attached & ~cc_sel_q & i_cc2_ra;
            o_cc_polarity            <= cc_sel_q;
        end
    end

    // ------------------------------------------------------------
    // usb mode and advertisement
    // ------------------------------------------------------------
    // type-c only until attach; the charging mode is chosen afterwards
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_usb_mode       <= charge_port_pkg::USB_NONE;
            o_adv_3a         <= 1'b0;
            o_sdp_900ma      <= 1'b0;
            o_charge_allowed <= 1'b0;
            o_mode_reserved  <= 1'b0;
        end else if (i_clk_en) begin
            o_usb_mode       <= attached ? mode_now : charge_port_pkg::USB_NONE;
            o_adv_3a         <= (mode_now == charge_port_pkg::USB_CDP) ||
                                (mode_now == charge_port_pkg::USB_DCP);
            o_sdp_900ma      <= i_usb3_host;
            // sdp and cdp charge only with a live host controller
            o_charge_allowed <= attached && ((mode_now == charge_port_pkg::USB_DCP) ||
                                ((mode_now != charge_port_pkg::USB_NONE) && i_host_active));
            o_mode_reserved  <= (mode_now == charge_port_pkg::USB_NONE);
        end
    end

    // ------------------------------------------------------------
    // data-line switches and dcp line conditioning
    // ------------------------------------------------------------
    // vconn current limit is deliberately not an input to the switch term
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_pass_switch_on   <= 1'b0;
            o_cdp_handshake_en <= 1'b0;
            o_dcp_short_en     <= 1'b0;
            o_dcp_div3_en      <= 1'b0;
            o_dcp_v12_en       <= 1'b0;
        end else if (i_clk_en) begin
            o_pass_switch_on   <= attached && i_power_on_gate_input && !i_ext_fet_ilim &&
                                  ((mode_now == charge_port_pkg::USB_SDP) ||
                                   (mode_now == charge_port_pkg::USB_CDP));
            o_cdp_handshake_en <= attached && (mode_now == charge_port_pkg::USB_CDP);
            o_dcp_short_en     <= attached && (mode_now == charge_port_pkg::USB_DCP) &&
                                  (dcp_state != charge_port_pkg::DCP_DIV3);
            o_dcp_div3_en      <= attached && (mode_now == charge_port_pkg::USB_DCP) &&
                                  (dcp_state == charge_port_pkg::DCP_DIV3);
            o_dcp_v12_en       <= attached && (mode_now == charge_port_pkg::USB_DCP) &&
                                  (dcp_state == charge_port_pkg::DCP_V12);
        end
    end

endmodule // charge_port_ctrl
`default_nettype wire

// >>> charge_port_ctrl_chk.sv
// port-level assertion checker for the charge-port mode controller
`timescale 1ns/1ps
`default_nettype none
module charge_port_ctrl_chk #(
    parameter int unsigned DEBOUNCE_CYC = 8
) (
    input wire logic       i_clk_sys,
    input wire logic       i_sys_rst,
    input wire logic       i_clk_en,
    input wire logic       i_power_on_gate_input,
    input wire logic       i_cc1_rd,
    input wire logic       i_cc2_rd,
    input wire logic       i_host_active,
    input wire logic       i_dcp_line_released,
    input wire logic       i_ext_fet_ilim,
    input wire logic       o_buck_enable,
    input wire logic       o_load_switch_gate_drive,
    input wire logic       o_vconn_cc1,
    input wire logic       o_vconn_cc2,
    input wire logic       o_cc_polarity,
    input wire logic       o_pass_switch_on,
    input wire logic       o_dcp_short_en,
    input wire logic       o_dcp_div3_en,
    input wire logic       o_dcp_v12_en,
    input wire logic [1:0] o_usb_mode,
    input wire logic       o_adv_3a,
    input wire logic       o_charge_allowed
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_sys_rst);
    // ----------------------------------------
    // helper: run length of sink presence
    // ----------------------------------------
    logic [15:0] rd_run_q;
    // saturates so a long attach never wraps back below the debounce figure
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) rd_run_q <= 16'h0000;
        else if (i_clk_en) rd_run_q <= !(i_cc1_rd || i_cc2_rd) ? 16'h0000 :
            (&rd_run_q ? rd_run_q : rd_run_q + 16'h0001);
    end
    // ----------------------------------------
    // properties
    // ----------------------------------------
    property p_buck_debounced; $rose(o_buck_enable) |-> rd_run_q >= DEBOUNCE_CYC; endproperty
    a_buck_debounced: assert property (p_buck_debounced) else $error("buck on early");
    property p_gate_tracks;
        o_load_switch_gate_drive && $past(i_clk_en) |-> o_buck_enable
            && (o_cc_polarity ? $past(i_cc2_rd) : $past(i_cc1_rd));
    endproperty
    a_gate_tracks: assert property (p_gate_tracks) else $error("gate drive mismatch");
    property p_pass_gated;
        o_pass_switch_on && $past(i_clk_en) |-> $past(i_power_on_gate_input) && !$past(i_ext_fet_ilim)
            && (o_usb_mode == 2'h1 || o_usb_mode == 2'h2);
    endproperty
    a_pass_gated: assert property (p_pass_gated) else $error("pass switch closed wrongly");
    property p_off_disabled;
        (!i_power_on_gate_input && i_clk_en) ##1 i_clk_en |=> !o_buck_enable && o_usb_mode == 2'h0;
    endproperty
    a_off_disabled: assert property (p_off_disabled) else $error("still on without enable");
    property p_vconn_side;
        (o_vconn_cc1 |-> o_cc_polarity && o_buck_enable) and (o_vconn_cc2 |-> !o_cc_polarity && o_buck_enable);
    endproperty
    a_vconn_side: assert property (p_vconn_side) else $error("vconn on sink pin");
    property p_div3_alone; o_dcp_div3_en |-> !o_dcp_v12_en && !o_dcp_short_en && o_usb_mode == 2'h3; endproperty
    a_div3_alone: assert property (p_div3_alone) else $error("divider overlaps");
    property p_v12_from_div3; $rose(o_dcp_v12_en) |-> $past(o_dcp_div3_en); endproperty
    a_v12_from_div3: assert property (p_v12_from_div3) else $error("1.2 v not from divider");
    property p_v12_dwell;
        $rose(o_dcp_v12_en) ##1 (i_clk_en && !i_dcp_line_released && o_usb_mode == 2'h3)[*8]
            |-> !o_dcp_v12_en && o_dcp_short_en;
    endproperty
    a_v12_dwell: assert property (p_v12_dwell) else $error("1.2 v dwell overran");
    property p_release;
        o_dcp_short_en && !o_dcp_v12_en && i_dcp_line_released && i_clk_en
            |-> ##[1:3] (o_dcp_div3_en || o_usb_mode != 2'h3);
    endproperty
    a_release: assert property (p_release) else $error("no return to divider");
    property p_adv; o_usb_mode != 2'h0 |-> o_adv_3a == (o_usb_mode != 2'h1); endproperty
    a_adv: assert property (p_adv) else $error("advertisement mismatch");
    property p_charge;
        o_charge_allowed && o_usb_mode != 2'h3 && $past(i_clk_en) |-> $past(i_host_active);
    endproperty
    a_charge: assert property (p_charge) else $error("charge without host");
    c_sdp: cover property (o_usb_mode == 2'h1 && o_pass_switch_on);
    c_cdp: cover property (o_usb_mode == 2'h2);
    c_short: cover property ($fell(o_dcp_v12_en) && o_dcp_short_en);
endmodule // charge_port_ctrl_chk
bind charge_port_ctrl charge_port_ctrl_chk #(.DEBOUNCE_CYC(DEBOUNCE_CYC)) u_chk (.*);
`default_nettype wire

// >>> sink_model.sv
// behavioural portable sink with its cable, as seen on cc and data lines
`timescale 1ns/1ps
`default_nettype none
module sink_model #(
    parameter int unsigned LAG = 2
) (
    input  wire logic i_clk_sys,
    input  wire logic i_attach,
    input  wire logic i_flip,
    input  wire logic i_cable_ra,
    input  wire logic i_short_std,
    input  wire logic i_release,
    output logic      o_cc1_rd,
    output logic      o_cc2_rd,
    output logic      o_cc1_ra,
    output logic      o_cc2_ra,
    output logic      o_short_seen,
    output logic      o_released
);
    int unsigned lag_q = 0;
    // lines move just after the edge so the controller never samples a change mid-edge
    always_ff @(posedge i_clk_sys) begin
        o_cc1_rd <= i_attach && !i_flip;
        o_cc2_rd <= i_attach && i_flip;
        o_cc1_ra <= i_attach && i_cable_ra && i_flip;
        o_cc2_ra <= i_attach && i_cable_ra && !i_flip;
        o_released <= !i_attach || i_release;
        // slow reaction: the device takes LAG cycles to probe the data lines
        lag_q <= (i_attach && i_short_std && !i_release) ? ((lag_q < LAG) ? lag_q + 1 : lag_q) : 0;
        o_short_seen <= (lag_q >= LAG - 1) && i_attach && i_short_std && !i_release;
    end
endmodule // sink_model
`default_nettype wire

// >>> tb_charge_port_ctrl.sv
// self-checking bench for the charge-port mode controller
`timescale 1ns/1ps
`default_nettype none
module tb_charge_port_ctrl;
    localparam int unsigned DEB = 8;
    localparam int unsigned DWL = 6;
    typedef struct packed { logic [15:0] val; logic [15:0] msk; } note_t;
    logic i_clk_sys, i_sys_rst, i_clk_en, i_power_on_gate_input, i_supply_ok, i_mode_select_a, i_mode_select_b;
    logic i_cc1_rd, i_cc2_rd, i_cc1_ra, i_cc2_ra, i_host_active, i_usb3_host, i_dcp_short_dev_seen;
    logic i_dcp_line_released, i_ext_fet_ilim, i_vconn_ilim, attach, flip, ra, short_std, rel;
    logic o_buck_enable, o_load_switch_gate_drive, o_vconn_cc1, o_vconn_cc2, o_cc_polarity, o_pass_switch_on;
    logic o_dcp_short_en, o_dcp_div3_en, o_dcp_v12_en, o_cdp_handshake_en, o_adv_3a, o_sdp_900ma;
    logic o_charge_allowed, o_mode_reserved;
    logic [1:0]  o_usb_mode;
    logic [15:0] obs;
    note_t       notes[$];
    note_t       nt;
    event        chk_ev;
    int          n_fail = 0;
    int          num_checks = 0;
    int          seed = 84284;
    logic [1:0]  sel_tab [4] = '{2'h2, 2'h3, 2'h1, 2'h0};
    assign obs = {o_buck_enable, o_load_switch_gate_drive, o_vconn_cc1, o_vconn_cc2, o_cc_polarity, o_pass_switch_on,
        o_dcp_short_en, o_dcp_div3_en, o_dcp_v12_en, o_cdp_handshake_en, o_usb_mode, o_adv_3a, o_charge_allowed,
        o_mode_reserved, o_sdp_900ma};
    charge_port_ctrl #(.DEBOUNCE_CYC(DEB), .DWELL_CYC(DWL)) u_charge_port_ctrl (.*);
    sink_model u_sink_model (.i_clk_sys(i_clk_sys), .i_attach(attach), .i_flip(flip), .i_cable_ra(ra),
        .i_short_std(short_std), .i_release(rel), .o_cc1_rd(i_cc1_rd), .o_cc2_rd(i_cc2_rd), .o_cc1_ra(i_cc1_ra),
        .o_cc2_ra(i_cc2_ra), .o_short_seen(i_dcp_short_dev_seen), .o_released(i_dcp_line_released));
    // ----------------------------------------
    // clock, scoreboard and closing
    // ----------------------------------------
    initial begin
        i_clk_sys = 1'b0;
        forever #2.5 i_clk_sys = ~i_clk_sys;
    end
    task automatic give_verdict();
        $display("checks %0d failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // oldest note against the settled outputs, masked to the bits it cares about
    initial begin
        forever begin
            @(chk_ev);
            nt = notes.pop_front();
            num_checks++;
            if ((obs & nt.msk) !== (nt.val & nt.msk)) begin
                n_fail++;
                $display("wrong value at %0t: got %h want %h mask %h", $time, obs, nt.val, nt.msk);
            end
        end
    end
    initial begin
        #(20000 * 5);
        n_fail++;
        give_verdict();
    end
    task automatic expect_out(input logic [15:0] v, input logic [15:0] m);
        notes.push_back('{v, m});
        ->chk_ev;
    endtask
    // attached picture for usb mode um, read from the live host inputs
    function automatic logic [15:0] att_exp(input logic [1:0] um, input logic f, input logic r);
        return {2'b11, r & f, r & ~f, f, (um == 2'h1) || (um == 2'h2), 1'b0, um == 2'h3, 1'b0,
            um == 2'h2, um, um != 2'h1, (um == 2'h3) || i_host_active, 1'b0, i_usb3_host};
    endfunction
    // plug in with one bounce and one clock freeze before the debounce completes
    task automatic plug(input logic f, input logic r);
        flip = f;
        ra = r;
        attach = 1'b1;
        repeat (DEB - 2) @(negedge i_clk_sys);
        attach = 1'b0;
        // two edges so the controller really samples the drop before the freeze
        repeat (2) @(negedge i_clk_sys);
        expect_out(16'h0000, 16'h8000);
        attach = 1'b1;
        i_clk_en = 1'b0;
        repeat (3) @(negedge i_clk_sys);
        i_clk_en = 1'b1;
        repeat (4) @(negedge i_clk_sys);
        expect_out(16'h0000, 16'h8000);
        repeat (DEB + 2) @(negedge i_clk_sys);
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {i_clk_en, i_power_on_gate_input, i_supply_ok, i_mode_select_a, i_mode_select_b} = 5'h00;
        {i_host_active, i_usb3_host, i_ext_fet_ilim, i_vconn_ilim, attach, flip, ra, short_std, rel} = 9'h000;
        i_sys_rst = 1'b1;
        repeat (5) @(negedge i_clk_sys);
        i_sys_rst = 1'b0;
        expect_out(16'h0000, 16'hFFFF);
        {i_clk_en, i_power_on_gate_input, i_supply_ok} = 3'h7;
        repeat (20) @(negedge i_clk_sys);
        expect_out(16'h0002, 16'hFFFE);
        for (int i = 0; i < 4; i++) begin
            {i_mode_select_a, i_mode_select_b} = sel_tab[i];
            i_host_active = 1'($random(seed));
            i_usb3_host = 1'($random(seed));
            plug(i[0], 1'($random(seed)));
            if (i == 3) expect_out(16'h0002, 16'h0402);
            else expect_out(att_exp(2'(i + 1), flip, ra), 16'hFFFF);
            if (i == 0) begin
                i_vconn_ilim = 1'b1;
                repeat (2) @(negedge i_clk_sys);
                expect_out(16'h0400, 16'h0400);
                i_ext_fet_ilim = 1'b1;
                repeat (2) @(negedge i_clk_sys);
                expect_out(16'h0000, 16'h0400);
                {i_ext_fet_ilim, i_vconn_ilim} = 2'h0;
            end
            if (i == 2) begin
                short_std = 1'b1;
                repeat (5) @(negedge i_clk_sys);
                expect_out(16'h0280, 16'h0380);
                repeat (DWL + 3) @(negedge i_clk_sys);
                expect_out(16'h0200, 16'h0380);
                rel = 1'b1;
                repeat (4) @(negedge i_clk_sys);
                expect_out(16'h0100, 16'h0380);
                {short_std, rel} = 2'h0;
                repeat (3 * DWL) @(negedge i_clk_sys);
                expect_out(16'h0100, 16'h0380);
            end
            attach = 1'b0;
            repeat (5) @(negedge i_clk_sys);
            expect_out({4'h0, flip, 11'h000}, 16'hFC30);
        end
        {i_mode_select_a, i_mode_select_b} = 2'h2;
        plug(1'b0, 1'b0);
        i_power_on_gate_input = 1'b0;
        repeat (3) @(negedge i_clk_sys);
        expect_out(16'h0000, 16'hC430);
        {i_power_on_gate_input, i_supply_ok} = 2'h2;
        repeat (20) @(negedge i_clk_sys);
        expect_out(16'h0000, 16'hC430);
        i_supply_ok = 1'b1;
        repeat (DEB + 8) @(negedge i_clk_sys);
        expect_out(att_exp(2'h1, 1'b0, 1'b0), 16'hFFFF);
        @(negedge i_clk_sys);
        give_verdict();
    end
endmodule // tb_charge_port_ctrl
`default_nettype wire
